/* File: design/nav_out_pkg.sv */
// Offsets, field layout and reset values of the navigation output bank
package nav_out_pkg;

  // ==========================================================================
  // Register offsets (word addresses on the serial register port)
  localparam logic [7:0] OFF_QUAT_AB      = 8'h75;
  localparam logic [7:0] OFF_QUAT_CD      = 8'h76;
  localparam logic [7:0] OFF_QUAT_TIME    = 8'h77;
  localparam logic [7:0] OFF_EULER_RP     = 8'h78;
  localparam logic [7:0] OFF_EULER_YAW    = 8'h79;
  localparam logic [7:0] OFF_EULER_TIME   = 8'h7A;
  localparam logic [7:0] OFF_POS_NORTH    = 8'h7B;
  localparam logic [7:0] OFF_POS_EAST     = 8'h7C;
  localparam logic [7:0] OFF_POS_UP       = 8'h7D;
  localparam logic [7:0] OFF_POS_TIME     = 8'h7E;
  localparam logic [7:0] OFF_VEL_NORTH    = 8'h7F;
  localparam logic [7:0] OFF_VEL_EAST     = 8'h80;
  localparam logic [7:0] OFF_VEL_UP       = 8'h81;
  localparam logic [7:0] OFF_RESERVED     = 8'h82;
  localparam logic [7:0] OFF_VEL_TIME     = 8'h83;
  localparam logic [7:0] OFF_RCV_LAT      = 8'h84;
  localparam logic [7:0] OFF_RCV_LON      = 8'h85;
  localparam logic [7:0] OFF_RCV_ALT      = 8'h86;
  localparam logic [7:0] OFF_RCV_COURSE   = 8'h87;
  localparam logic [7:0] OFF_RCV_SPEED    = 8'h88;
  localparam logic [7:0] OFF_RCV_TIME     = 8'h89;
  localparam logic [7:0] OFF_RCV_DATE     = 8'h8A;
  localparam logic [7:0] OFF_SAT_12       = 8'h8B;
  localparam logic [7:0] OFF_SAT_34       = 8'h8C;

  // ==========================================================================
  // Field layout and fill values
  localparam int         HALF_HI_LSB      = 16;
  localparam int         BYTE3_LSB        = 24;
  localparam int         BYTE1_LSB        = 8;
  localparam logic [15:0] UNUSED_HALF     = 16'h0000;
  localparam logic [7:0]  RESERVED_BYTE   = 8'h00;
  localparam logic [31:0] WORD_RESET      = 32'h0000_0000;
  localparam logic [31:0] RESERVED_WORD   = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_WORD   = 32'h0000_0000;

  // ==========================================================================
  // Host-side scale of the fixed-point fields (true value = raw / scale)
  localparam real QUAT_SCALE  = 29789.09091;
  localparam real EULER_SCALE = 5215.18917;

endpackage : nav_out_pkg

/* File: design/nav_out_regs.sv */
// Read-only attitude and navigation output register bank
// ============================================================================
module nav_out_regs
  import nav_out_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Host register port
  input  wire logic        rd_req,
  input  wire logic [7:0]  rd_addr,
  input  wire logic        wr_req,
  input  wire logic [7:0]  wr_addr,
  output logic             rd_valid,
  output logic [31:0]      rd_data,
  output logic             rd_hit,
  output logic             wr_refused,
  // Estimator: attitude
  input  wire logic        quat_update,
  input  wire logic [15:0] quat_a,
  input  wire logic [15:0] quat_b,
  input  wire logic [15:0] quat_c,
  input  wire logic [15:0] quat_d,
  input  wire logic [31:0] quat_time,
  input  wire logic        euler_update,
  input  wire logic [15:0] euler_roll,
  input  wire logic [15:0] euler_pitch,
  input  wire logic [15:0] euler_yaw,
  input  wire logic [31:0] euler_time,
  // Estimator: position relative to home, velocity
  input  wire logic        pos_update,
  input  wire logic [31:0] pos_north,
  input  wire logic [31:0] pos_east,
  input  wire logic [31:0] pos_up,
  input  wire logic [31:0] pos_time,
  input  wire logic        vel_update,
  input  wire logic [31:0] vel_north,
  input  wire logic [31:0] vel_east,
  input  wire logic [31:0] vel_up,
  input  wire logic [31:0] vel_time,
  // Satellite receiver report
  input  wire logic        rcv_update,
  input  wire logic [31:0] rcv_latitude,
  input  wire logic [31:0] rcv_longitude,
  input  wire logic [31:0] rcv_altitude,
  input  wire logic [31:0] rcv_course,
  input  wire logic [31:0] rcv_speed,
  input  wire logic [31:0] rcv_time,
  input  wire logic [7:0]  rcv_year,
  input  wire logic [7:0]  rcv_month,
  input  wire logic [7:0]  rcv_day,
  input  wire logic        sat_update,
  input  wire logic [7:0]  sat1_id,
  input  wire logic [7:0]  sat1_snr,
  input  wire logic [7:0]  sat2_id,
  input  wire logic [7:0]  sat2_snr,
  input  wire logic [7:0]  sat3_id,
  input  wire logic [7:0]  sat3_snr,
  input  wire logic [7:0]  sat4_id,
  input  wire logic [7:0]  sat4_snr
);

  // ==========================================================================
  // Storage
  logic [31:0] quat_ab_reg;
  logic [31:0] quat_cd_reg;
  logic [31:0] quat_time_reg;
  logic [31:0] euler_rp_reg;
  logic [31:0] euler_yaw_reg;
  logic [31:0] euler_time_reg;
  logic [31:0] pos_n_reg;
  logic [31:0] pos_e_reg;
  logic [31:0] pos_u_reg;
  logic [31:0] pos_time_reg;
  logic [31:0] vel_n_reg;
  logic [31:0] vel_e_reg;
  logic [31:0] vel_u_reg;
  logic [31:0] vel_time_reg;
  logic [31:0] rcv_lat_reg;
  logic [31:0] rcv_lon_reg;
  logic [31:0] rcv_alt_reg;
  logic [31:0] rcv_course_reg;
  logic [31:0] rcv_speed_reg;
  logic [31:0] rcv_time_reg;
  logic [31:0] rcv_date_reg;
  logic [31:0] sat_12_reg;
  logic [31:0] sat_34_reg;
  logic [31:0] rd_data_next;

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr >= OFF_QUAT_AB) && (addr <= OFF_SAT_34);
  endfunction : is_mapped

  // ==========================================================================
  // Attitude group; quaternion and Euler words each land in one edge so halves never tear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quat_ab_reg   <= WORD_RESET;
      quat_cd_reg   <= WORD_RESET;
      quat_time_reg <= WORD_RESET;
    end else if (quat_update) begin
      quat_ab_reg   <= {quat_a, quat_b};
      quat_cd_reg   <= {quat_c, quat_d};
      quat_time_reg <= quat_time;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      euler_rp_reg   <= WORD_RESET;
      euler_yaw_reg  <= WORD_RESET;
      euler_time_reg <= WORD_RESET;
    end else if (euler_update) begin
      euler_rp_reg   <= {euler_roll, euler_pitch};
      euler_yaw_reg  <= {euler_yaw, UNUSED_HALF};
      euler_time_reg <= euler_time;
    end
  end

  // ==========================================================================
  // Position and velocity; offsets from home are formed upstream
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_n_reg    <= WORD_RESET;
      pos_e_reg    <= WORD_RESET;
      pos_u_reg    <= WORD_RESET;
      pos_time_reg <= WORD_RESET;
    end else if (pos_update) begin
      pos_n_reg    <= pos_north;
      pos_e_reg    <= pos_east;
      pos_u_reg    <= pos_up;
      pos_time_reg <= pos_time;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vel_n_reg    <= WORD_RESET;
      vel_e_reg    <= WORD_RESET;
      vel_u_reg    <= WORD_RESET;
      vel_time_reg <= WORD_RESET;
    end else if (vel_update) begin
      vel_n_reg    <= vel_north;
      vel_e_reg    <= vel_east;
      vel_u_reg    <= vel_up;
      vel_time_reg <= vel_time;
    end
  end

  // ==========================================================================
  // Receiver report
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rcv_lat_reg    <= WORD_RESET;
      rcv_lon_reg    <= WORD_RESET;
      rcv_alt_reg    <= WORD_RESET;
      rcv_course_reg <= WORD_RESET;
      rcv_speed_reg  <= WORD_RESET;
      rcv_time_reg   <= WORD_RESET;
      rcv_date_reg   <= WORD_RESET;
    end else if (rcv_update) begin
      rcv_lat_reg    <= rcv_latitude;
      rcv_lon_reg    <= rcv_longitude;
      rcv_alt_reg    <= rcv_altitude;
      rcv_course_reg <= rcv_course;
      rcv_speed_reg  <= rcv_speed;
      rcv_time_reg   <= rcv_time;
      rcv_date_reg   <= {RESERVED_BYTE, rcv_year, rcv_month, rcv_day};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sat_12_reg <= WORD_RESET;
      sat_34_reg <= WORD_RESET;
    end else if (sat_update) begin
      sat_12_reg <= {sat1_id, sat1_snr, sat2_id, sat2_snr};
      sat_34_reg <= {sat3_id, sat3_snr, sat4_id, sat4_snr};
    end
  end

  // ==========================================================================
  // Read decode
  always_comb begin
    unique case (rd_addr)
      OFF_QUAT_AB:    rd_data_next = quat_ab_reg;
      OFF_QUAT_CD:    rd_data_next = quat_cd_reg;
      OFF_QUAT_TIME:  rd_data_next = quat_time_reg;
      OFF_EULER_RP:   rd_data_next = euler_rp_reg;
      OFF_EULER_YAW:  rd_data_next = euler_yaw_reg;
      OFF_EULER_TIME: rd_data_next = euler_time_reg;
      OFF_POS_NORTH:  rd_data_next = pos_n_reg;
      OFF_POS_EAST:   rd_data_next = pos_e_reg;
      OFF_POS_UP:     rd_data_next = pos_u_reg;
      OFF_POS_TIME:   rd_data_next = pos_time_reg;
      OFF_VEL_NORTH:  rd_data_next = vel_n_reg;
      OFF_VEL_EAST:   rd_data_next = vel_e_reg;
      OFF_VEL_UP:     rd_data_next = vel_u_reg;
      OFF_RESERVED:   rd_data_next = RESERVED_WORD;
      OFF_VEL_TIME:   rd_data_next = vel_time_reg;
      OFF_RCV_LAT:    rd_data_next = rcv_lat_reg;
      OFF_RCV_LON:    rd_data_next = rcv_lon_reg;
      OFF_RCV_ALT:    rd_data_next = rcv_alt_reg;
      OFF_RCV_COURSE: rd_data_next = rcv_course_reg;
      OFF_RCV_SPEED:  rd_data_next = rcv_speed_reg;
      OFF_RCV_TIME:   rd_data_next = rcv_time_reg;
      OFF_RCV_DATE:   rd_data_next = rcv_date_reg;
      OFF_SAT_12:     rd_data_next = sat_12_reg;
      OFF_SAT_34:     rd_data_next = sat_34_reg;
      default:        rd_data_next = UNMAPPED_WORD;
    endcase
  end

  // Read sees the value before a same-cycle update
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data  <= WORD_RESET;
      rd_hit   <= 1'b0;
    end else begin
      rd_valid <= rd_req;
      rd_hit   <= rd_req && is_mapped(rd_addr);
      if (rd_req) begin
        rd_data <= rd_data_next;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_refused <= 1'b0;
    end else begin
      wr_refused <= wr_req;
    end
  end

  // ==========================================================================
  // Assertions
  property p_quat_c;
    @(posedge clk) disable iff (!rst_n)
    quat_update |=> quat_cd_reg[31:HALF_HI_LSB] == $past(quat_c);
  endproperty
  a_quat_c: assert property (p_quat_c) else $error("quat C half wrong");

  property p_quat_d_read;
    @(posedge clk) disable iff (!rst_n)
    quat_update ##1 (rd_req && rd_addr == OFF_QUAT_CD) |=>
      rd_data[HALF_HI_LSB-1:0] == $past(quat_d, 2);
  endproperty
  a_quat_d_read: assert property (p_quat_d_read) else $error("quat D read wrong");

  property p_quat_time_hold;
    @(posedge clk) disable iff (!rst_n)
    quat_update ##1 (!quat_update)[*3] |-> quat_time_reg == $past(quat_time, 3);
  endproperty
  a_quat_time_hold: assert property (p_quat_time_hold) else $error("quat time lost");

  property p_roll_pitch;
    @(posedge clk) disable iff (!rst_n)
    euler_update |=> euler_rp_reg == {$past(euler_roll), $past(euler_pitch)};
  endproperty
  a_roll_pitch: assert property (p_roll_pitch) else $error("roll/pitch packing wrong");

  property p_yaw_read;
    @(posedge clk) disable iff (!rst_n)
    rd_req && rd_addr == OFF_EULER_YAW |=>
      rd_valid && rd_data == {$past(euler_yaw_reg[31:HALF_HI_LSB]), UNUSED_HALF};
  endproperty
  a_yaw_read: assert property (p_yaw_read) else $error("yaw read wrong");

  property p_reserved;
    @(posedge clk) disable iff (!rst_n)
    rd_req && rd_addr == OFF_RESERVED |=> rd_hit && rd_data == RESERVED_WORD;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved slot not zero");

  property p_date;
    @(posedge clk) disable iff (!rst_n)
    rcv_update |=> rcv_date_reg[31:BYTE3_LSB] == RESERVED_BYTE
      && rcv_date_reg[BYTE1_LSB-1:0] == $past(rcv_day);
  endproperty
  a_date: assert property (p_date) else $error("date packing wrong");

  property p_sat;
    @(posedge clk) disable iff (!rst_n)
    sat_update |=> sat_34_reg[31:BYTE3_LSB] == $past(sat3_id)
      && sat_34_reg[BYTE1_LSB-1:0] == $past(sat4_snr);
  endproperty
  a_sat: assert property (p_sat) else $error("satellite packing wrong");

  property p_vel_time;
    @(posedge clk) disable iff (!rst_n)
    vel_update ##1 (rd_req && rd_addr == OFF_VEL_TIME) |=> rd_data == $past(vel_time, 2);
  endproperty
  a_vel_time: assert property (p_vel_time) else $error("velocity time read wrong");

  property p_write_no_effect;
    @(posedge clk) disable iff (!rst_n)
    wr_req && !pos_update && !vel_update |=>
      $stable(pos_n_reg) && $stable(vel_u_reg) && wr_refused;
  endproperty
  a_write_no_effect: assert property (p_write_no_effect) else $error("write changed bank");

  property p_unmapped;
    @(posedge clk) disable iff (!rst_n)
    rd_req && !is_mapped(rd_addr) |=> !rd_hit && rd_data == UNMAPPED_WORD;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_quat_ab;
    @(posedge clk) disable iff (!rst_n)
    quat_update |=> quat_ab_reg == {$past(quat_a), $past(quat_b)};
  endproperty
  a_quat_ab: assert property (p_quat_ab) else $error("quat A/B packing wrong");

  property p_euler_time;
    @(posedge clk) disable iff (!rst_n)
    euler_update |=> euler_time_reg == $past(euler_time);
  endproperty
  a_euler_time: assert property (p_euler_time) else $error("Euler time wrong");

  property p_pos_words;
    @(posedge clk) disable iff (!rst_n)
    pos_update |=> pos_e_reg == $past(pos_east) && pos_u_reg == $past(pos_up);
  endproperty
  a_pos_words: assert property (p_pos_words) else $error("position words wrong");

  property p_rcv_words;
    @(posedge clk) disable iff (!rst_n)
    rcv_update |=> rcv_lat_reg == $past(rcv_latitude) && rcv_time_reg == $past(rcv_time);
  endproperty
  a_rcv_words: assert property (p_rcv_words) else $error("receiver words wrong");

  c_quat_read:  cover property (@(posedge clk) disable iff (!rst_n)
    quat_update ##1 rd_req && rd_addr == OFF_QUAT_CD);
  c_sat_read:   cover property (@(posedge clk) disable iff (!rst_n)
    sat_update ##[1:5] rd_req && rd_addr == OFF_SAT_34);
  c_write:      cover property (@(posedge clk) disable iff (!rst_n) wr_req && is_mapped(wr_addr));
  c_same_cycle: cover property (@(posedge clk) disable iff (!rst_n)
    pos_update && rd_req && rd_addr == OFF_POS_NORTH);

endmodule : nav_out_regs

/* File: sim/host_model.sv */
// Host side of the register port: issues reads and writes, one at a time
module host_model (
  input  wire logic        clk,
  input  wire logic        rd_valid,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_hit,
  input  wire logic        wr_refused,
  output logic             rd_req,
  output logic [7:0]       rd_addr,
  output logic             wr_req,
  output logic [7:0]       wr_addr
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Idle state from time zero
  initial begin
    rd_req  = 1'b0;
    rd_addr = 8'h00;
    wr_req  = 1'b0;
    wr_addr = 8'h00;
  end

  // ==========================================================================
  // Transfers: request at a falling edge, answer taken one cycle later
  task automatic read_word(input logic [7:0] a, output logic [31:0] d,
                           output logic h, output logic v);
    @(negedge clk);
    rd_req  = 1'b1;
    rd_addr = a;
    @(negedge clk);
    d = rd_data;
    h = rd_hit;
    v = rd_valid;
    rd_req = 1'b0;
    // Address no longer qualified, so show its inverse
    rd_addr = ~a;
  endtask : read_word

  task automatic write_word(input logic [7:0] a, output logic r);
    @(negedge clk);
    wr_req  = 1'b1;
    wr_addr = a;
    @(negedge clk);
    r = wr_refused;
    wr_req  = 1'b0;
    wr_addr = ~a;
  endtask : write_word
endmodule : host_model

/* File: sim/tb.sv */
// Self-checking bench for the navigation output register bank
module tb
  import nav_out_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        rd_req, wr_req, rd_valid, rd_hit, wr_refused;
  logic [7:0]  rd_addr, wr_addr;
  logic [31:0] rd_data;
  logic [5:0]  upd = 6'h00;
  logic [31:0] fw [0:15] = '{default: 32'h0};
  logic [15:0] hw [0:6] = '{default: 16'h0};
  logic [7:0]  bw [0:10] = '{default: 8'h0};
  int          num_errors = 0;
  int          samples_checked = 0;

  always #5 clk = ~clk;

  // ==========================================================================
  // Design and host
  nav_out_regs u_nav_out_regs (
    .clk(clk), .rst_n(rst_n), .rd_req(rd_req), .rd_addr(rd_addr), .wr_req(wr_req),
    .wr_addr(wr_addr), .rd_valid(rd_valid), .rd_data(rd_data), .rd_hit(rd_hit),
    .wr_refused(wr_refused), .quat_update(upd[0]), .quat_a(hw[0]), .quat_b(hw[1]),
    .quat_c(hw[2]), .quat_d(hw[3]), .quat_time(fw[0]), .euler_update(upd[1]),
    .euler_roll(hw[4]), .euler_pitch(hw[5]), .euler_yaw(hw[6]), .euler_time(fw[1]),
    .pos_update(upd[2]), .pos_north(fw[2]), .pos_east(fw[3]), .pos_up(fw[4]),
    .pos_time(fw[5]), .vel_update(upd[3]), .vel_north(fw[6]), .vel_east(fw[7]),
    .vel_up(fw[8]), .vel_time(fw[9]), .rcv_update(upd[4]), .rcv_latitude(fw[10]),
    .rcv_longitude(fw[11]), .rcv_altitude(fw[12]), .rcv_course(fw[13]),
    .rcv_speed(fw[14]), .rcv_time(fw[15]), .rcv_year(bw[0]), .rcv_month(bw[1]),
    .rcv_day(bw[2]), .sat_update(upd[5]), .sat1_id(bw[3]), .sat1_snr(bw[4]),
    .sat2_id(bw[5]), .sat2_snr(bw[6]), .sat3_id(bw[7]), .sat3_snr(bw[8]),
    .sat4_id(bw[9]), .sat4_snr(bw[10]));

  host_model u_host_model (
    .clk(clk), .rd_valid(rd_valid), .rd_data(rd_data), .rd_hit(rd_hit),
    .wr_refused(wr_refused), .rd_req(rd_req), .rd_addr(rd_addr), .wr_req(wr_req),
    .wr_addr(wr_addr));

  // ==========================================================================
  // Helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Expected word from the stimulus; unused yaw half, reserved slot read zero
  function automatic logic [31:0] exp_word(input logic [7:0] a);
    case (a) inside
      8'h75: return {hw[0], hw[1]};
      8'h76: return {hw[2], hw[3]};
      8'h77: return fw[0];
      8'h78: return {hw[4], hw[5]};
      8'h79: return {hw[6], 16'h0000};
      8'h7A: return fw[1];
      [8'h7B:8'h81]: return fw[a - 8'h79];
      8'h83: return fw[9];
      [8'h84:8'h89]: return fw[a - 8'h7A];
      8'h8A: return {8'h00, bw[0], bw[1], bw[2]};
      8'h8B: return {bw[3], bw[4], bw[5], bw[6]};
      8'h8C: return {bw[7], bw[8], bw[9], bw[10]};
      default: return 32'h0000_0000;
    endcase
  endfunction : exp_word

  // Reads 0x73..0x8D, including unmapped neighbours on both sides
  task automatic sweep();
    logic [31:0] d;
    logic        h, v;
    for (int a = 8'h73; a <= 8'h8D; a++) begin
      u_host_model.read_word(8'(a), d, h, v);
      check({31'h0, v}, 32'h1);
      check({31'h0, h}, {31'h0, (a >= 8'h75 && a <= 8'h8C)});
      check(d, exp_word(8'(a)));
    end
  endtask : sweep

  // ==========================================================================
  // Scenarios
  task automatic test_reset();
    sweep();
    $display("test reset done");
  endtask : test_reset

  task automatic test_load();
    for (int i = 0; i < 16; i++) fw[i] = 32'(32'h3F80_0000 + i * 32'h0101_0107);
    for (int i = 0; i < 7; i++) hw[i] = 16'(16'h8001 + i * 16'h1111);
    for (int i = 0; i < 11; i++) bw[i] = 8'(8'hC0 + i * 8'h0B);
    @(negedge clk);
    upd = 6'h3F;
    @(negedge clk);
    upd = 6'h00;
    sweep();
    $display("test load done");
  endtask : test_load

  task automatic test_write();
    logic r;
    logic [7:0] wa [0:2] = '{8'h76, 8'h82, 8'hFF};
    for (int i = 0; i < 3; i++) begin
      u_host_model.write_word(wa[i], r);
      check({31'h0, r}, 32'h1);
    end
    @(negedge clk);
    check({31'h0, wr_refused}, 32'h0);
    sweep();
    $display("test write done");
  endtask : test_write

  // Inputs change without a strobe, then only the quaternion group updates
  task automatic test_hold();
    logic [31:0] d, old_cd, old_rp;
    logic        h, v;
    old_cd = exp_word(8'h76);
    old_rp = exp_word(8'h78);
    hw[2] = 16'h7FFF;
    hw[4] = 16'h1234;
    u_host_model.read_word(8'h76, d, h, v);
    check(d, old_cd);
    @(negedge clk);
    upd = 6'h01;
    @(negedge clk);
    upd = 6'h00;
    u_host_model.read_word(8'h76, d, h, v);
    check(d, {16'h7FFF, hw[3]});
    u_host_model.read_word(8'h78, d, h, v);
    check(d, old_rp);
    $display("test hold done");
  endtask : test_hold

  // Updates one cycle before a read, and in the same cycle as a read
  task automatic test_update_read();
    logic [31:0] d, old_n;
    logic        h, v;
    old_n = exp_word(8'h7B);
    hw[3] = 16'h0F0F;
    fw[2] = 32'h4120_0000;
    fw[9] = 32'hC2C8_0000;
    bw[7] = 8'hA5;
    fork
      begin
        @(negedge clk);
        upd = 6'h21;
        @(negedge clk);
        upd = 6'h00;
      end
      begin
        @(negedge clk);
        u_host_model.read_word(8'h76, d, h, v);
        check(d, {hw[2], 16'h0F0F});
      end
    join
    u_host_model.read_word(8'h8C, d, h, v);
    check(d, {8'hA5, bw[8], bw[9], bw[10]});
    fork
      begin
        @(negedge clk);
        upd = 6'h04;
        @(negedge clk);
        upd = 6'h08;
        @(negedge clk);
        upd = 6'h00;
      end
      begin
        u_host_model.read_word(8'h7B, d, h, v);
        check(d, old_n);
        u_host_model.read_word(8'h83, d, h, v);
        check(d, 32'hC2C8_0000);
      end
    join
    u_host_model.read_word(8'h7B, d, h, v);
    check(d, 32'h4120_0000);
    @(negedge clk);
    check({31'h0, rd_valid}, 32'h0);
    $display("test update read done");
  endtask : test_update_read

  // ==========================================================================
  // Closing and run control
  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  // Whole run is a few hundred cycles; ample margin
  initial begin
    #20us;
    num_errors++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    test_reset();
    test_load();
    test_write();
    test_hold();
    test_update_read();
    stop_test();
  end
endmodule : tb
